// ### sensor_spi_pkg.sv
// constants for the sensor spi result and alert block
package sensor_spi_pkg;
  localparam logic [6:0] ADDR_THR_HI_LO   = 7'h06;
  localparam logic [6:0] ADDR_THR_HI_HI   = 7'h07;
  localparam logic [6:0] ADDR_THR_LO_LO   = 7'h08;
  localparam logic [6:0] ADDR_THR_LO_HI   = 7'h09;
  localparam logic [6:0] ADDR_PIN_MODE    = 7'h0A;
  localparam logic [6:0] ADDR_POWER       = 7'h0B;
  localparam logic [6:0] ADDR_STATUS      = 7'h20;
  localparam logic [6:0] ADDR_PROX_LOW    = 7'h21;
  localparam logic [6:0] ADDR_PROX_HIGH   = 7'h22;
  localparam logic [6:0] ADDR_OSC_LOW     = 7'h23;
  localparam logic [6:0] ADDR_OSC_MID     = 7'h24;
  localparam logic [6:0] ADDR_OSC_HIGH    = 7'h25;
  localparam logic [2:0] MODE_READY       = 3'h4;
  localparam logic [2:0] MODE_COMPARE     = 3'h2;
  localparam logic [2:0] MODE_WAKE        = 3'h1;
  localparam logic [2:0] MODE_OFF         = 3'h0;
  localparam logic [15:0] THR_HI_RESET    = 16'hFFFF;
  localparam logic [15:0] THR_LO_RESET    = 16'h0000;
  localparam int          CMD_BITS        = 8;
  localparam int          STAT_READY_BIT  = 6;
  localparam int          STAT_WAKE_BIT   = 5;
  localparam int          STAT_CMP_BIT    = 4;
  localparam int          PULSE_NS        = 80;
  localparam int          CLK_NS          = 8;
  localparam int          PULSE_CYCLES    = PULSE_NS / CLK_NS;
endpackage

// ### byte_skid.sv
// two-entry buffer for received write words
`timescale 1ns/1ns
`default_nettype none
module byte_skid (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        flush,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [14:0] in_data,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic      [14:0] out_data
);
  logic [14:0] mem_q [2];
  logic        wr_q;
  logic        rd_q;
  logic [1:0]  cnt_q;
  logic        push;
  logic        pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q[0] <= 15'h0000;
      mem_q[1] <= 15'h0000;
    end else if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else if (flush) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// ### sensor_spi_result_and_alert.sv
// spi slave register access, result snapshot and alert pin logic
`timescale 1ns/1ns
`default_nettype none
module sensor_spi_result_and_alert
  import sensor_spi_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        active_low_select,
  input  wire logic        sclk,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  output logic             alert_out_pin,
  output logic             power_state_bit,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_prox,
  input  wire logic [23:0] conv_osc,
  input  wire logic        osc_stopped
);
  typedef enum logic [2:0] {
    ST_CMD  = 3'b001,
    ST_DATA = 3'b010,
    ST_IDLE = 3'b100
  } spi_state_type;

  // pin synchronisers; first stage read only by second
  logic [1:0] cs_s_q, ck_s_q, di_s_q;
  logic       cs_q, ck_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s_q <= 2'b11;
      ck_s_q <= 2'b00;
      di_s_q <= 2'b00;
      cs_q   <= 1'b1;
      ck_q   <= 1'b0;
    end else begin
      cs_s_q <= {cs_s_q[0], active_low_select};
      ck_s_q <= {ck_s_q[0], sclk};
      di_s_q <= {di_s_q[0], sdi};
      cs_q   <= cs_s_q[1];
      ck_q   <= ck_s_q[1];
    end
  end
  logic sel, sel_start, rise, fall;
  assign sel       = !cs_s_q[1];
  assign sel_start = sel && cs_q;
  assign rise      = sel && ck_s_q[1] && !ck_q;
  assign fall      = sel && !ck_s_q[1] && ck_q;

  spi_state_type state_q;
  logic [2:0]  bit_q;
  logic [7:0]  shin_q, shout_q;
  logic        rd_q;
  logic [6:0]  addr_q;
  logic        load_out_q;
  logic        snap_req;
  logic [7:0]  sh_next;
  assign sh_next = {shin_q[6:0], di_s_q[1]};

  logic [14:0] wr_word;
  logic        wr_valid, wr_ready, fifo_valid, fifo_ready;
  logic [14:0] fifo_data;

  // only a falling select starts anything; deselect returns to idle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      bit_q      <= 3'h0;
      shin_q     <= 8'h00;
      rd_q       <= 1'b0;
      addr_q     <= 7'h00;
      load_out_q <= 1'b0;
    end else if (!sel) begin
      state_q    <= ST_IDLE;
      load_out_q <= 1'b0;
    end else if (sel_start) begin
      state_q <= ST_CMD;
      bit_q   <= 3'h0;
    end else if (rise && wr_ready) begin
      shin_q <= sh_next;
      bit_q  <= bit_q + 3'h1;
      load_out_q <= 1'b0;
      if (bit_q == 3'h7) begin
        unique case (state_q)
          ST_CMD: begin
            rd_q       <= sh_next[7];
            addr_q     <= sh_next[6:0];
            state_q    <= ST_DATA;
            load_out_q <= sh_next[7];
          end
          ST_DATA: begin
            addr_q     <= addr_q + 7'h01;
            load_out_q <= rd_q;
          end
          ST_IDLE: state_q <= ST_IDLE;
        endcase
      end
    end else begin
      load_out_q <= 1'b0;
    end
  end
  // snapshot taken when a read command naming the proximity low byte lands
  assign snap_req = rise && wr_ready && state_q == ST_CMD && bit_q == 3'h7
                    && sh_next[7] && sh_next[6:0] == ADDR_PROX_LOW;
  // a byte commits only on its own 8th rising edge, so early deselect drops it
  assign wr_valid = rise && state_q == ST_DATA && bit_q == 3'h7 && !rd_q;
  assign wr_word  = {addr_q, sh_next};

  // a host clock edge that arrives while the buffer is full is dropped, not held
  byte_skid u_skid (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .flush     (1'b0),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_word),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );
  assign fifo_ready = 1'b1;

  // registers
  logic [7:0]  thr_hi_buf_q, thr_lo_buf_q;
  logic [15:0] thr_hi_q, thr_lo_q;
  logic [2:0]  pin_mode_q;
  logic        pwr_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_hi_buf_q <= THR_HI_RESET[7:0];
      thr_lo_buf_q <= THR_LO_RESET[7:0];
      thr_hi_q     <= THR_HI_RESET;
      thr_lo_q     <= THR_LO_RESET;
      pin_mode_q   <= MODE_OFF;
      pwr_q        <= 1'b0;
    end else if (fifo_valid) begin
      unique case (fifo_data[14:8])
        ADDR_THR_HI_LO: thr_hi_buf_q <= fifo_data[7:0];
        ADDR_THR_HI_HI: thr_hi_q <= {fifo_data[7:0], thr_hi_buf_q};
        ADDR_THR_LO_LO: thr_lo_buf_q <= fifo_data[7:0];
        ADDR_THR_LO_HI: thr_lo_q <= {fifo_data[7:0], thr_lo_buf_q};
        ADDR_PIN_MODE:  pin_mode_q <= fifo_data[2:0];
        ADDR_POWER:     pwr_q <= fifo_data[0];
        default:        pwr_q <= pwr_q;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) power_state_bit <= 1'b0;
    else power_state_bit <= pwr_q;
  end

  // latest conversion and snapshot; conversions gated by power state
  logic        conv_ok;
  logic [15:0] live_prox_q, prox_q;
  logic [23:0] live_osc_q, osc_q;
  logic        fresh_q;
  assign conv_ok = conv_done && pwr_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      live_prox_q <= 16'h0000;
      live_osc_q  <= 24'h000000;
      prox_q      <= 16'h0000;
      osc_q       <= 24'h000000;
    end else begin
      if (conv_ok) begin
        live_prox_q <= conv_prox;
        live_osc_q  <= conv_osc;
      end
      if (snap_req) begin
        prox_q <= live_prox_q;
        osc_q  <= live_osc_q;
      end
    end
  end
  // new result wins over a same-cycle clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) fresh_q <= 1'b0;
    else if (conv_ok) fresh_q <= 1'b1;
    else if (snap_req) fresh_q <= 1'b0;
  end

  // comparator and wake state
  logic cmp_q, wake_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_q  <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      if (live_prox_q > thr_hi_q) cmp_q <= 1'b1;
      else if (live_prox_q < thr_lo_q) cmp_q <= 1'b0;
      if (pin_mode_q != MODE_WAKE) wake_q <= 1'b0;
      else if (live_prox_q > thr_hi_q) wake_q <= 1'b1;
    end
  end

  // read mux
  function automatic logic [7:0] reg_read(input logic [6:0] a);
    unique case (a)
      ADDR_THR_HI_LO: reg_read = thr_hi_q[7:0];
      ADDR_THR_HI_HI: reg_read = thr_hi_q[15:8];
      ADDR_THR_LO_LO: reg_read = thr_lo_q[7:0];
      ADDR_THR_LO_HI: reg_read = thr_lo_q[15:8];
      ADDR_PIN_MODE:  reg_read = {5'h00, pin_mode_q};
      ADDR_POWER:     reg_read = {7'h00, pwr_q};
      ADDR_STATUS:    reg_read = {osc_stopped, !fresh_q, !wake_q, !cmp_q, 4'h0};
      ADDR_PROX_LOW:  reg_read = prox_q[7:0];
      ADDR_PROX_HIGH: reg_read = prox_q[15:8];
      ADDR_OSC_LOW:   reg_read = osc_q[7:0];
      ADDR_OSC_MID:   reg_read = osc_q[15:8];
      ADDR_OSC_HIGH:  reg_read = osc_q[23:16];
      default:        reg_read = 8'h00;
    endcase
  endfunction

  // byte loads after the edge that completes the prior byte; bits leave on falls
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shout_q <= 8'h00;
      sdo     <= 1'b0;
      sdo_oe  <= 1'b0;
    end else if (!sel) begin
      sdo_oe <= 1'b0;
      sdo    <= 1'b0;
    end else if (load_out_q) begin
      shout_q <= reg_read(addr_q);
    end else if (fall && state_q == ST_DATA && rd_q) begin
      sdo     <= shout_q[7];
      sdo_oe  <= 1'b1;
      shout_q <= {shout_q[6:0], 1'b0};
    end
  end

  // alert pin
  logic [3:0] pulse_q;
  logic       reading;
  logic       pin_ready_q;
  assign reading = sel && state_q == ST_DATA && rd_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) pulse_q <= 4'h0;
    else if (conv_ok && reading && pin_mode_q == MODE_READY) pulse_q <= 4'(PULSE_CYCLES);
    else if (pulse_q != 4'h0) pulse_q <= pulse_q - 4'h1;
  end
  // in ready mode a result landing mid-read only pulses the pin; the status flag still records it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) pin_ready_q <= 1'b0;
    else if (conv_ok && !reading) pin_ready_q <= 1'b1;
    else if (snap_req) pin_ready_q <= 1'b0;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) alert_out_pin <= 1'b1;
    else begin
      unique case (pin_mode_q)
        MODE_READY:   alert_out_pin <= !((pin_ready_q && !reading) || pulse_q != 4'h0);
        MODE_COMPARE: alert_out_pin <= !cmp_q;
        MODE_WAKE:    alert_out_pin <= !wake_q;
        default:      alert_out_pin <= 1'b1;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### sensor_spi_checker.sv
// port assertions for the sensor spi block
`timescale 1ns/1ns
`default_nettype none
module sensor_spi_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic active_low_select,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic alert_out_pin,
  input wire logic power_state_bit
);
  // raw pin rises; the design lags by its synchroniser
  logic [7:0] rise_q;
  logic       sclk_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_q <= 8'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (active_low_select) rise_q <= 8'h00;
      else if (sclk && !sclk_q) rise_q <= rise_q + 8'h01;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  property p_rst_out;
    $rose(rst_n) |-> alert_out_pin && !sdo_oe && !power_state_bit;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
  property p_oe_desel;
    active_low_select [*4] |-> !sdo_oe;
  endproperty
  a_oe_desel: assert property (p_oe_desel) else $error("sdo driven while deselected");
  property p_oe_cmd;
    !active_low_select && rise_q < 8'h08 |-> !sdo_oe;
  endproperty
  a_oe_cmd: assert property (p_oe_cmd) else $error("sdo driven in command byte");
  property p_oe_rose;
    $rose(sdo_oe) |-> rise_q == 8'h08;
  endproperty
  a_oe_rose: assert property (p_oe_rose) else $error("read data not after 8 clocks");
  property p_oe_hold;
    sdo_oe && !active_low_select |=> sdo_oe;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("sdo dropped inside frame");
  property p_sdo_stable;
    (sdo_oe && sclk) [*2] |-> $stable(sdo);
  endproperty
  a_sdo_stable: assert property (p_sdo_stable) else $error("sdo moved while clock high");
  property p_power_cnt;
    $changed(power_state_bit) |-> rise_q >= 8'h10;
  endproperty
  a_power_cnt: assert property (p_power_cnt) else $error("write before 16th clock");
  property p_alert_stby;
    (!power_state_bit && active_low_select) [*6] |-> $stable(alert_out_pin);
  endproperty
  a_alert_stby: assert property (p_alert_stby) else $error("alert moved in standby");
  c_read: cover property ($rose(sdo_oe));
  c_alert: cover property ($fell(alert_out_pin));
  c_power: cover property ($rose(power_state_bit));
  c_pulse: cover property ($fell(alert_out_pin) ##[1:12] $rose(alert_out_pin));
endmodule
bind sensor_spi_result_and_alert sensor_spi_checker i_sensor_spi_checker (.sys_clk(sys_clk),
  .rst_n(rst_n), .active_low_select(active_low_select), .sclk(sclk), .sdo(sdo), .sdo_oe(sdo_oe),
  .alert_out_pin(alert_out_pin), .power_state_bit(power_state_bit));
`default_nettype wire

// ### spi_host_model.sv
// spi host model, mode 0, 160 ns serial clock
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  input  wire logic sys_clk,
  input  wire logic sdo,
  input  wire logic sdo_oe,
  output logic      active_low_select,
  output logic      sclk,
  output logic      sdi
);
  logic [7:0] tx_q [8];
  logic [7:0] rx_q [8];
  // released line never shows a stale bit
  wire line_w = sdo_oe ? sdo : ~sdo;
  initial begin
    active_low_select = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task automatic half();
    repeat (10) @(negedge sys_clk);
  endtask
  // cut: bits clocked before deselect, 0 for a whole frame
  task automatic frame(input logic [7:0] cmd, input int n, input int cut);
    logic [7:0] sh;
    int bits;
    bits = (cut != 0) ? cut : 8 * (1 + n);
    active_low_select = 1'b0;
    half();
    for (int b = 0; b < bits; b++) begin
      sh = (b < 8) ? cmd : tx_q[b / 8 - 1];
      sdi = sh[7 - b % 8];
      half();
      sclk = 1'b1;
      if (b >= 8) rx_q[b / 8 - 1][7 - b % 8] = line_w;
      half();
      sclk = 1'b0;
    end
    half();
    active_low_select = 1'b1;
    sdi = ~sdi;
    repeat (6) half();
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the sensor spi block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sensor_spi_pkg::*;
  logic        sys_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        conv_done = 1'b0;
  logic [15:0] conv_prox = 16'h0000;
  logic [23:0] conv_osc  = 24'h000000;
  logic        osc_stopped = 1'b1;
  int          bad_count = 0;
  int          n_tests   = 0;
  wire active_low_select, sclk, sdi, sdo, sdo_oe, alert_out_pin, power_state_bit;
  initial forever #4 sys_clk = ~sys_clk;
  sensor_spi_result_and_alert i_sensor_spi_result_and_alert (.sys_clk(sys_clk), .rst_n(rst_n),
    .active_low_select(active_low_select), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .alert_out_pin(alert_out_pin), .power_state_bit(power_state_bit), .conv_done(conv_done),
    .conv_prox(conv_prox), .conv_osc(conv_osc), .osc_stopped(osc_stopped));
  spi_host_model i_spi_host_model (.sys_clk(sys_clk), .sdo(sdo), .sdo_oe(sdo_oe),
    .active_low_select(active_low_select), .sclk(sclk), .sdi(sdi));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("tests=%0d bad=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int cut);
    i_spi_host_model.tx_q[0] = d;
    i_spi_host_model.frame({1'b0, a}, 1, cut);
  endtask
  task automatic rd(input logic [6:0] a, input int n);
    i_spi_host_model.frame({1'b1, a}, n, 0);
  endtask
  // alert settles within two cycles, four allowed
  task automatic conv(input logic [15:0] p, input logic [23:0] o);
    @(negedge sys_clk);
    conv_done = 1'b1;
    conv_prox = p;
    conv_osc = o;
    @(negedge sys_clk);
    conv_done = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic t_power();
    conv(16'h0F0F, 24'h0F0F0F);
    rd(ADDR_STATUS, 1);
    check(i_spi_host_model.rx_q[0], 8'hF0);
    wr(ADDR_POWER, 8'h01, 0);
    check(power_state_bit, 1'b1);
    wr(ADDR_POWER, 8'h00, 15);
    check(power_state_bit, 1'b1);
    rd(ADDR_POWER, 1);
    check(i_spi_host_model.rx_q[0], 8'h01);
  endtask
  task automatic t_snap();
    logic [39:0] v;
    v = {24'hABCDEF, 16'h1234};
    wr(ADDR_PIN_MODE, {5'h00, MODE_READY}, 0);
    conv(16'h1234, 24'hABCDEF);
    check(alert_out_pin, 1'b0);
    rd(ADDR_STATUS, 1);
    check(i_spi_host_model.rx_q[0], 8'hB0);
    rd(ADDR_PROX_LOW, 5);
    for (int i = 0; i < 5; i++) check(i_spi_host_model.rx_q[i], v[8 * i +: 8]);
    check(alert_out_pin, 1'b1);
    conv(16'h5678, 24'h111111);
    conv(16'h9ABC, 24'h222222);
    rd(ADDR_PROX_HIGH, 1);
    check(i_spi_host_model.rx_q[0], 8'h12);
    rd(ADDR_PROX_LOW, 2);
    check({i_spi_host_model.rx_q[1], i_spi_host_model.rx_q[0]}, 16'h9ABC);
  endtask
  task automatic t_pulse();
    fork
      rd(ADDR_PROX_LOW, 2);
      begin
        repeat (250) @(negedge sys_clk);
        conv_done = 1'b1;
        conv_prox = 16'h4321;
        conv_osc = 24'h333333;
        @(negedge sys_clk);
        conv_done = 1'b0;
        repeat (2) @(negedge sys_clk);
        check(alert_out_pin, 1'b0);
        repeat (20) @(negedge sys_clk);
        check(alert_out_pin, 1'b1);
      end
    join
    check({i_spi_host_model.rx_q[1], i_spi_host_model.rx_q[0]}, 16'h9ABC);
    check(alert_out_pin, 1'b1);
    rd(ADDR_STATUS, 1);
    check(i_spi_host_model.rx_q[0], 8'hB0);
  endtask
  task automatic t_thr();
    logic [31:0] v;
    v = 32'h00800100;
    wr(ADDR_THR_HI_LO, 8'h55, 0);
    rd(ADDR_THR_HI_LO, 1);
    check(i_spi_host_model.rx_q[0], 8'hFF);
    for (int i = 0; i < 4; i++) i_spi_host_model.tx_q[i] = v[8 * i +: 8];
    i_spi_host_model.frame({1'b0, ADDR_THR_HI_LO}, 4, 0);
    rd(ADDR_THR_HI_LO, 4);
    for (int i = 0; i < 4; i++) check(i_spi_host_model.rx_q[i], v[8 * i +: 8]);
  endtask
  task automatic t_alert();
    wr(ADDR_PIN_MODE, {5'h00, MODE_COMPARE}, 0);
    conv(16'h0200, 24'h000001);
    check(alert_out_pin, 1'b0);
    conv(16'h00C0, 24'h000002);
    check(alert_out_pin, 1'b0);
    conv(16'h0040, 24'h000003);
    check(alert_out_pin, 1'b1);
    wr(ADDR_PIN_MODE, {5'h00, MODE_WAKE}, 0);
    conv(16'h0200, 24'h000004);
    check(alert_out_pin, 1'b0);
    conv(16'h0040, 24'h000005);
    check(alert_out_pin, 1'b0);
    wr(ADDR_PIN_MODE, 8'h03, 0);
    check(alert_out_pin, 1'b1);
  endtask
  initial begin
    repeat (15) @(negedge sys_clk);
    check({sdo_oe, alert_out_pin, power_state_bit}, 3'b010);
    @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_power();
    t_snap();
    t_pulse();
    t_thr();
    t_alert();
    end_sim();
  end
endmodule
`default_nettype wire
